// ### logic/flash_seq_pkg.sv
package flash_seq_pkg;
    // -----------------------------------------------------------------
    // bus geometry
    // -----------------------------------------------------------------
    localparam int ADDR_W = 32; // cpu byte address width
    localparam int DATA_W = 32; // one bus write cycle carries a word
    localparam int CMD_ADDR_W = 16; // low address bits compared in commands

    // -----------------------------------------------------------------
    // command cycle addresses and data
    // -----------------------------------------------------------------
    localparam logic [CMD_ADDR_W-1:0] UNLOCK_ADDR1 = 16'h5400;
    localparam logic [CMD_ADDR_W-1:0] UNLOCK_ADDR2 = 16'haa00;
    localparam logic [DATA_W-1:0] UNLOCK_DATA1 = 32'h0000_00aa;
    localparam logic [DATA_W-1:0] UNLOCK_DATA2 = 32'h0000_0055;
    localparam logic [DATA_W-1:0] READ_CMD_DATA = 32'h0000_00f0;
    localparam logic [DATA_W-1:0] PROG_CMD_DATA = 32'h0000_00a0;
    localparam logic [DATA_W-1:0] ERASE_CMD_DATA = 32'h0000_0080;
    localparam logic [DATA_W-1:0] IDENT_CMD_DATA = 32'h0000_0090;
    localparam logic [DATA_W-1:0] CHIP_ERASE_DATA = 32'h0000_0010;
    localparam logic [DATA_W-1:0] BLOCK_ERASE_DATA = 32'h0000_0030;

    // -----------------------------------------------------------------
    // page and block layout
    // -----------------------------------------------------------------
    localparam int PAGE_CNT_W = 7; // counts the words of one page
    localparam logic [PAGE_CNT_W-1:0] PAGE_LAST = 7'h7f; // 128 words
    localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;
    localparam int BLOCK_W = 3; // block index width
    localparam int BLOCK_COUNT = 8; // blocks with a protection bit
    localparam int BLOCK_LSB = 15; // lowest address bit of block index

    // kind of automatic operation handed to the array macro
    typedef enum logic [1:0] {
        op_none,
        op_page,
        op_chip,
        op_block
    } op_kind_type;
endpackage

// ### logic/flash_command_sequencer.sv
`timescale 1ns/1ps
// How it works
// R1: only read state or automatic state
// R2: automatic state entered only via valid sequence
// R3: no valid read data while automatic
// R4: only hardware reset leaves automatic state; code also leaves it on op_done, from st_wait to st_read
// R5: read state after reset and normal completion
// R6: read/reset or hardware reset restores read
// R7: single word 0xf0 write restores read
// R8: read/reset acts after its third cycle
// R9: identifier output holds until read/reset
// R10: cpu cancels partial commands with read/reset
// R11: commands decoded from ordered address/data writes
// R12: any deviating write abandons the command
// R13: cpu keeps off flash during sequences
// R14: cpu checks idle flag before first cycle
// R15: cpu fixes wrong writes by software reset
// R16: cpu reset aborts automatic work, restores read
// R17: software repeats work cut by reset
// R18: reset vector fetched in read state
// R19: page program, chip/block erase, block protect
// R20: cpu raises no exceptions during automatic work
// R21: idle flag low while busy, high after
// R22: failed operation locks until hardware reset
// R23: page program starts after third cycle
// R24: erases start after sixth cycle
module flash_command_sequencer (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    input wire logic wr_valid,
    input wire logic [flash_seq_pkg::ADDR_W-1:0] wr_addr,
    input wire logic [flash_seq_pkg::DATA_W-1:0] wr_data,
    input wire logic [flash_seq_pkg::BLOCK_COUNT-1:0] block_protect,
    input wire logic op_done,
    input wire logic op_fail,
    output logic sequencer_idle_flag,
    output logic auto_mode,
    output logic read_data_ok,
    output logic identifier_mode,
    output logic fail_locked,
    output logic op_start,
    output flash_seq_pkg::op_kind_type op_kind,
    output logic prog_word_valid,
    output logic [flash_seq_pkg::ADDR_W-1:0] prog_word_addr,
    output logic [flash_seq_pkg::DATA_W-1:0] prog_word_data
);

    // -----------------------------------------------------------------
    // state and storage
    // -----------------------------------------------------------------
    typedef enum logic [3:0] {
        st_read,   // array readable, waiting for a first cycle
        st_cyc1,   // first unlock cycle seen
        st_cyc2,   // second unlock cycle seen
        st_ers3,   // erase command cycle seen
        st_ers4,   // fourth cycle, unlock again
        st_ers5,   // fifth cycle, unlock again
        st_ident,  // identifier output selected
        st_fill,   // page program running, taking page words
        st_wait,   // automatic operation running in the array
        st_locked  // automatic operation failed
    } seq_state_type;

    typedef struct packed {
        seq_state_type st;
        logic [flash_seq_pkg::PAGE_CNT_W-1:0] cnt; // page word count
        logic [flash_seq_pkg::BLOCK_W-1:0] blk; // selected block
        logic idle; // idle flag as software sees it
        logic busy; // automatic state
        logic rd_ok; // read data may be used
        logic ident; // identifier output selected
        logic lock; // failed and locked
        logic start; // one-cycle start of an operation
        flash_seq_pkg::op_kind_type kind; // operation handed out
        logic wvalid; // one-cycle page word strobe
        logic [flash_seq_pkg::ADDR_W-1:0] waddr; // page word address
        logic [flash_seq_pkg::DATA_W-1:0] wdata; // page word data
    } seq_type;

    localparam seq_type SEQ_RESET = '{
        st: st_read, cnt: '0, blk: '0, idle: 1'b1, busy: 1'b0, rd_ok: 1'b1, ident: 1'b0,
        lock: 1'b0, start: 1'b0, kind: flash_seq_pkg::op_none, wvalid: 1'b0,
        waddr: '0, wdata: '0
    };

    seq_type seq_r; // registered state
    seq_type seq_nxt; // next state

    // -----------------------------------------------------------------
    // write-cycle decode
    // -----------------------------------------------------------------
    logic [flash_seq_pkg::CMD_ADDR_W-1:0] cmd_addr; // compared address bits
    logic at_addr1; // write lands on the first unlock address
    logic unlock1; // first unlock cycle
    logic unlock2; // second unlock cycle
    logic read_cmd; // single-word read command
    logic [flash_seq_pkg::BLOCK_W-1:0] wr_blk; // block of the write

    assign cmd_addr = wr_addr[flash_seq_pkg::CMD_ADDR_W-1:0];
    assign at_addr1 = cmd_addr == flash_seq_pkg::UNLOCK_ADDR1;
    assign unlock1 = at_addr1 && wr_data == flash_seq_pkg::UNLOCK_DATA1; // [R11]
    assign unlock2 = cmd_addr == flash_seq_pkg::UNLOCK_ADDR2
        && wr_data == flash_seq_pkg::UNLOCK_DATA2; // [R11]
    assign read_cmd = wr_data == flash_seq_pkg::READ_CMD_DATA;
    assign wr_blk = wr_addr[flash_seq_pkg::BLOCK_LSB +: flash_seq_pkg::BLOCK_W];

    // -----------------------------------------------------------------
    // next-state logic
    // -----------------------------------------------------------------
    // strobes default low, state moves only on a cpu write or array event
    always_comb begin
        seq_nxt = seq_r;
        seq_nxt.start = 1'b0;
        seq_nxt.wvalid = 1'b0;
        unique case (seq_r.st)
            // read and identifier states wait for a first cycle
            st_read, st_ident: begin
                if (wr_valid) begin
                    if (read_cmd) begin
                        seq_nxt.st = st_read; // [R7]
                    end else if (unlock1) begin
                        seq_nxt.st = st_cyc1; // [R2]
                    end
                end
            end
            // second cycle must be the second unlock
            st_cyc1: begin
                if (wr_valid) begin
                    seq_nxt.st = unlock2 ? st_cyc2 : st_read; // [R12]
                end
            end
            // third cycle selects the command
            st_cyc2: begin
                if (wr_valid) begin
                    seq_nxt.st = st_read; // [R8] [R12]
                    if (at_addr1) begin
                        unique case (wr_data)
                            flash_seq_pkg::PROG_CMD_DATA: begin
                                seq_nxt.st = st_fill; // [R23]
                                seq_nxt.start = 1'b1;
                                seq_nxt.kind = flash_seq_pkg::op_page;
                                seq_nxt.cnt = '0;
                            end
                            flash_seq_pkg::ERASE_CMD_DATA: seq_nxt.st = st_ers3;
                            flash_seq_pkg::IDENT_CMD_DATA: seq_nxt.st = st_ident; // [R9]
                            default: seq_nxt.st = st_read; // [R6]
                        endcase
                    end
                end
            end
            // fourth and fifth cycles unlock once more
            st_ers3: begin
                if (wr_valid) begin
                    seq_nxt.st = unlock1 ? st_ers4 : st_read; // [R12]
                end
            end
            st_ers4: begin
                if (wr_valid) begin
                    seq_nxt.st = unlock2 ? st_ers5 : st_read; // [R12]
                end
            end
            // sixth cycle picks chip or block erase
            st_ers5: begin
                if (wr_valid) begin
                    seq_nxt.st = st_read; // [R12]
                    if (at_addr1 && wr_data == flash_seq_pkg::CHIP_ERASE_DATA) begin
                        // all blocks protected: nothing to erase
                        if (!(&block_protect)) begin
                            seq_nxt.st = st_wait; // [R24]
                            seq_nxt.start = 1'b1;
                            seq_nxt.kind = flash_seq_pkg::op_chip;
                        end
                    end else if (wr_data == flash_seq_pkg::BLOCK_ERASE_DATA) begin
                        seq_nxt.blk = wr_blk;
                        // protected block stays untouched
                        if (!block_protect[wr_blk]) begin
                            seq_nxt.st = st_wait; // [R24] [R19]
                            seq_nxt.start = 1'b1;
                            seq_nxt.kind = flash_seq_pkg::op_block;
                        end
                    end
                end
            end
            // page words: first names the page top, the rest follow on
            st_fill: begin
                if (op_fail) begin
                    seq_nxt.st = st_locked; // [R22]
                end else if (wr_valid) begin
                    // every write is page data here, read/reset has no effect
                    if (seq_r.cnt == '0) begin
                        seq_nxt.waddr = wr_addr;
                        seq_nxt.blk = wr_blk;
                        seq_nxt.wvalid = !block_protect[wr_blk]; // [R19]
                    end else begin
                        seq_nxt.waddr = seq_r.waddr + flash_seq_pkg::WORD_STEP;
                        seq_nxt.wvalid = !block_protect[seq_r.blk]; // [R19]
                    end
                    seq_nxt.wdata = wr_data;
                    seq_nxt.cnt = seq_r.cnt + {{(flash_seq_pkg::PAGE_CNT_W-1){1'b0}}, 1'b1};
                    if (seq_r.cnt == flash_seq_pkg::PAGE_LAST) begin
                        seq_nxt.st = st_wait;
                    end
                end
            end
            // array works alone, cpu writes are not accepted
            st_wait: begin
                if (op_fail) begin
                    seq_nxt.st = st_locked; // [R22]
                end else if (op_done) begin
                    seq_nxt.st = st_read; // [R5] [R21]
                    seq_nxt.kind = flash_seq_pkg::op_none;
                end
            end
            // only sys_rst leaves this state
            st_locked: begin
                seq_nxt.st = st_locked; // [R22] [R4]
            end
        endcase
        // flags follow the state they enter with
        seq_nxt.busy = seq_nxt.st inside {st_fill, st_wait, st_locked}; // [R1]
        seq_nxt.idle = !seq_nxt.busy; // [R21]
        seq_nxt.ident = seq_nxt.st == st_ident; // [R9]
        seq_nxt.rd_ok = !seq_nxt.busy && !seq_nxt.ident; // [R3]
        seq_nxt.lock = seq_nxt.st == st_locked;
    end

    // -----------------------------------------------------------------
    // state register
    // -----------------------------------------------------------------
    // cpu reset (pin or watchdog) aborts all and restores read
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            seq_r <= SEQ_RESET; // [R16] [R18] [R4]
        end else if (clk_en) begin
            seq_r <= seq_nxt;
        end
    end

    // -----------------------------------------------------------------
    // outputs, all straight from the state register
    // -----------------------------------------------------------------
    assign sequencer_idle_flag = seq_r.idle;
    assign auto_mode = seq_r.busy;
    assign read_data_ok = seq_r.rd_ok;
    assign identifier_mode = seq_r.ident;
    assign fail_locked = seq_r.lock;
    assign op_start = seq_r.start;
    assign op_kind = seq_r.kind;
    assign prog_word_valid = seq_r.wvalid;
    assign prog_word_addr = seq_r.waddr;
    assign prog_word_data = seq_r.wdata;

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // reset leaves read state with idle flag set; never disabled, reset is the trigger
    property p_reset_read;
        disable iff (1'b0) sys_rst |=> read_data_ok && sequencer_idle_flag && !auto_mode;
    endproperty
    a_reset_read: assert property (p_reset_read) // [R5]
        else $error("not in read state after reset");
    // busy never offers read data
    property p_no_read_busy;
        auto_mode |-> !read_data_ok && !sequencer_idle_flag;
    endproperty
    a_no_read_busy: assert property (p_no_read_busy) // [R3]
        else $error("read data offered while automatic");
    // automatic state only after third or sixth cycle
    property p_entry;
        $rose(auto_mode) |-> $past(seq_r.st) inside {st_cyc2, st_ers5};
    endproperty
    a_entry: assert property (p_entry) // [R2]
        else $error("automatic state without a command");
    // read command from any non-busy state except st_ers5 gives read
    property p_read_cmd;
        clk_en && wr_valid && read_cmd && !auto_mode && seq_r.st != st_ers5
            |=> read_data_ok;
    endproperty
    a_read_cmd: assert property (p_read_cmd) // [R7]
        else $error("read command ignored");
    // page command starts page program next cycle
    property p_start_prog;
        clk_en && wr_valid && seq_r.st == st_cyc2 && at_addr1
            && wr_data == flash_seq_pkg::PROG_CMD_DATA
            |=> op_start && op_kind == flash_seq_pkg::op_page && auto_mode;
    endproperty
    a_start_prog: assert property (p_start_prog) // [R23]
        else $error("page program not started");
    // chip erase starts after the sixth cycle
    property p_start_chip;
        clk_en && wr_valid && seq_r.st == st_ers5 && at_addr1
            && wr_data == flash_seq_pkg::CHIP_ERASE_DATA && !(&block_protect)
            |=> op_start && op_kind == flash_seq_pkg::op_chip ##1 !op_start;
    endproperty
    a_start_chip: assert property (p_start_chip) // [R24]
        else $error("chip erase not started");
    // bad second cycle abandons the command
    property p_bad_cycle;
        clk_en && wr_valid && seq_r.st == st_cyc1 && !unlock2 |=> seq_r.st == st_read;
    endproperty
    a_bad_cycle: assert property (p_bad_cycle) // [R12]
        else $error("bad cycle not abandoned");
    // failure lock holds
    property p_locked;
        fail_locked |=> fail_locked && auto_mode;
    endproperty
    a_locked: assert property (p_locked) // [R22]
        else $error("lock released without reset");
    // normal completion sets idle flag
    property p_done;
        clk_en && seq_r.st == st_wait && op_done && !op_fail
            |=> sequencer_idle_flag && read_data_ok;
    endproperty
    a_done: assert property (p_done) // [R21]
        else $error("idle flag not set on completion");
    // identifier output holds without writes
    property p_ident;
        identifier_mode && !wr_valid |=> identifier_mode;
    endproperty
    a_ident: assert property (p_ident) // [R9]
        else $error("identifier output dropped");
    // protected block never receives page words
    property p_protect;
        prog_word_valid |-> !block_protect[seq_r.blk];
    endproperty
    a_protect: assert property (p_protect) // [R19]
        else $error("word sent to protected block");
    c_page_done: cover property (op_kind == flash_seq_pkg::op_page ##1 op_done);
    c_block: cover property (op_start && op_kind == flash_seq_pkg::op_block);
    c_ident: cover property ($rose(identifier_mode));
    c_lock: cover property ($rose(fail_locked));

endmodule

// ### dv/cpu_bus_model.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// cpu side of the flash write port: one full-word bus write per wr call
// ---------------------------------------------------------------------
module cpu_bus_model (
    input wire logic clk,
    input wire logic idle_flag,
    output logic wr_valid,
    output logic [flash_seq_pkg::ADDR_W-1:0] wr_addr,
    output logic [flash_seq_pkg::DATA_W-1:0] wr_data
);
    // bus idle at time zero
    initial begin
        wr_valid = 1'b0;
        wr_addr = 32'h0000_0000;
        wr_data = 32'h0000_0000;
    end

    // one 32-bit write launched at the falling edge, held one cycle
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        @(negedge clk);
        wr_valid = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk);
        wr_valid = 1'b0;
        // released bus shows the inverse so a stale copy cannot match
        wr_addr = ~a;
        wr_data = ~d;
    endtask

    // unlock pair then the command cycle, run once idle is seen or after 300 cycles
    task automatic cmd(input logic [31:0] a3, input logic [31:0] d3);
        int n;
        n = 0;
        while (idle_flag !== 1'b1 && n < 300) begin
            @(negedge clk);
            n++;
        end
        wr({16'h0000, flash_seq_pkg::UNLOCK_ADDR1}, flash_seq_pkg::UNLOCK_DATA1);
        wr({16'h0000, flash_seq_pkg::UNLOCK_ADDR2}, flash_seq_pkg::UNLOCK_DATA2);
        wr(a3, d3);
    endtask

    // software reset used to cancel a partial or wrong sequence
    task automatic soft_reset;
        cmd({16'h0000, flash_seq_pkg::UNLOCK_ADDR1}, flash_seq_pkg::READ_CMD_DATA);
    endtask
endmodule

// ### dv/flash_command_sequencer_test.sv
`timescale 1ns/1ps
module flash_command_sequencer_test;
    // -----------------------------------------------------------------
    // signals
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] n; // writes in the row
        logic [2:0][15:0] a; // low address of each write, first at [2]
        logic [2:0][7:0] d; // data of each write
        logic [2:0] exp; // identifier, auto, idle
    } row_type;
    logic clk, sys_rst, clk_en, op_done, op_fail, wr_valid;
    logic [31:0] wr_addr, wr_data, prog_word_addr, prog_word_data, page_top;
    logic [7:0] block_protect;
    logic sequencer_idle_flag, auto_mode, read_data_ok, identifier_mode;
    logic fail_locked, op_start, prog_word_valid;
    flash_seq_pkg::op_kind_type op_kind;
    int errors, n_checks, n_words, n_starts, cycles;
    row_type rows [9];

    flash_command_sequencer DUT (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
        .block_protect(block_protect), .op_done(op_done), .op_fail(op_fail),
        .sequencer_idle_flag(sequencer_idle_flag), .auto_mode(auto_mode),
        .read_data_ok(read_data_ok), .identifier_mode(identifier_mode),
        .fail_locked(fail_locked), .op_start(op_start), .op_kind(op_kind),
        .prog_word_valid(prog_word_valid), .prog_word_addr(prog_word_addr),
        .prog_word_data(prog_word_data));
    cpu_bus_model cpu (.clk(clk), .idle_flag(sequencer_idle_flag), .wr_valid(wr_valid),
        .wr_addr(wr_addr), .wr_data(wr_data));

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // idle flag, automatic state, read data valid and failure lock
    task automatic st(input logic i, input logic a, input logic r, input logic l);
        @(negedge clk);
        check("idle", sequencer_idle_flag, i);
        check("auto", auto_mode, a);
        check("read_ok", read_data_ok, r);
        check("locked", fail_locked, l);
    endtask

    task automatic complete_run;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic do_reset(input int n);
        @(negedge clk);
        sys_rst = 1'b1;
        repeat (n) @(negedge clk);
        sys_rst = 1'b0;
    endtask

    // array macro answer: one-cycle done or fail pulse
    task automatic pulse(input logic fail);
        @(negedge clk);
        op_done = ~fail;
        op_fail = fail;
        @(negedge clk);
        op_done = 1'b0;
        op_fail = 1'b0;
    endtask

    // page command then the given number of page words from page_top
    task automatic run_page(input int words);
        int s;
        s = n_starts;
        n_words = 0;
        cpu.cmd(32'h0000_5400, 32'h0000_00a0);
        st(1'b0, 1'b1, 1'b0, 1'b0);
        check("starts", n_starts - s, 1);
        check("kind", op_kind, flash_seq_pkg::op_page);
        for (int i = 0; i < words; i++)
            cpu.wr(page_top + 32'(4 * i), 32'hc0de_0000 + 32'(i));
    endtask

    // erase command: five cycles, then the chosen sixth cycle
    task automatic erase(input logic [31:0] a6, input logic [31:0] d6);
        cpu.cmd(32'h0000_5400, 32'h0000_0080);
        cpu.wr(32'h0000_5400, 32'h0000_00aa);
        cpu.wr(32'h0000_aa00, 32'h0000_0055);
        st(1'b1, 1'b0, 1'b1, 1'b0);
        cpu.wr(a6, d6);
    endtask

    // -----------------------------------------------------------------
    // clock, monitor of the array side and timeout
    // -----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(negedge clk) begin
        if (op_start === 1'b1)
            n_starts++;
        if (prog_word_valid === 1'b1) begin
            check("word_addr", prog_word_addr, page_top + 32'(4 * n_words));
            check("word_data", prog_word_data, 32'hc0de_0000 + 32'(n_words));
            n_words++;
        end
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end

    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        op_done = 1'b0;
        op_fail = 1'b0;
        block_protect = 8'h00;
        page_top = 32'h0000_0200;
        rows[0] = '{2'd3, {16'h5400, 16'haa00, 16'h5400}, {8'haa, 8'h55, 8'h90}, 3'b101};
        rows[1] = '{2'd1, {16'h1234, 16'h0000, 16'h0000}, {8'hf0, 8'h00, 8'h00}, 3'b001};
        rows[2] = '{2'd3, {16'h5400, 16'haa00, 16'h5400}, {8'haa, 8'h55, 8'h90}, 3'b101};
        rows[3] = '{2'd3, {16'h5400, 16'haa00, 16'h5400}, {8'haa, 8'h55, 8'hf0}, 3'b001};
        rows[4] = '{2'd3, {16'h5400, 16'haa00, 16'h5400}, {8'haa, 8'h99, 8'ha0}, 3'b001};
        rows[5] = '{2'd3, {16'h5400, 16'h5400, 16'h5400}, {8'haa, 8'h55, 8'ha0}, 3'b001};
        rows[6] = '{2'd3, {16'h5400, 16'haa00, 16'h1234}, {8'haa, 8'h55, 8'ha0}, 3'b001};
        rows[7] = '{2'd3, {16'h5400, 16'haa00, 16'h5400}, {8'haa, 8'h55, 8'h80}, 3'b001};
        rows[8] = '{2'd3, {16'h5400, 16'haa00, 16'h5400}, {8'haa, 8'h55, 8'hf0}, 3'b001};
        repeat (8) @(negedge clk);
        sys_rst = 1'b0;
        st(1'b1, 1'b0, 1'b1, 1'b0);
        check("kind", op_kind, flash_seq_pkg::op_none);
        clk_en = 1'b0;
        cpu.cmd(32'h0000_5400, 32'h0000_0090);
        clk_en = 1'b1;
        st(1'b1, 1'b0, 1'b1, 1'b0);
        $display("test reset done");
        // command table: identifier, read, read/reset, bad-cycle and erase-entry write shapes and their resulting mode
        for (int r = 0; r < 9; r++) begin
            for (int k = 0; k < rows[r].n; k++)
                cpu.wr({16'h0000, rows[r].a[2-k]}, {24'h000000, rows[r].d[2-k]});
            @(negedge clk);
            check("ident", identifier_mode, rows[r].exp[2]);
            check("auto", auto_mode, rows[r].exp[1]);
            check("idle", sequencer_idle_flag, rows[r].exp[0]);
            if (rows[r].exp[2] == 1'b0)
                check("read_ok", read_data_ok, 1'b1);
        end
        $display("test command table done");
        // full page, commands ignored while busy, normal end
        run_page(128);
        repeat (3) @(negedge clk);
        check("words", n_words, 128);
        cpu.wr(32'h0000_1234, 32'h0000_00f0);
        st(1'b0, 1'b1, 1'b0, 1'b0);
        pulse(1'b0);
        st(1'b1, 1'b0, 1'b1, 1'b0);
        check("kind", op_kind, flash_seq_pkg::op_none);
        $display("test page done");
        // hardware reset mid page, then the page is repeated
        run_page(10);
        do_reset(2);
        st(1'b1, 1'b0, 1'b1, 1'b0);
        run_page(128);
        pulse(1'b0);
        st(1'b1, 1'b0, 1'b1, 1'b0);
        $display("test reset in page done");
        // chip erase that fails: locked until hardware reset
        erase(32'h0000_5400, 32'h0000_0010);
        st(1'b0, 1'b1, 1'b0, 1'b0);
        check("kind", op_kind, flash_seq_pkg::op_chip);
        pulse(1'b1);
        cpu.wr(32'h0000_5400, 32'h0000_00aa);
        cpu.wr(32'h0000_aa00, 32'h0000_0055);
        cpu.wr(32'h0000_5400, 32'h0000_00f0);
        st(1'b0, 1'b1, 1'b0, 1'b1);
        do_reset(1);
        st(1'b1, 1'b0, 1'b1, 1'b0);
        $display("test erase fail done");
        // block erase: open block runs, protected block and fully protected chip do not
        block_protect = 8'h08;
        erase(32'h0001_0000, 32'h0000_0030);
        st(1'b0, 1'b1, 1'b0, 1'b0);
        check("kind", op_kind, flash_seq_pkg::op_block);
        pulse(1'b0);
        st(1'b1, 1'b0, 1'b1, 1'b0);
        erase(32'h0001_8000, 32'h0000_0030);
        st(1'b1, 1'b0, 1'b1, 1'b0);
        block_protect = 8'hff;
        erase(32'h0000_5400, 32'h0000_0010);
        st(1'b1, 1'b0, 1'b1, 1'b0);
        cpu.soft_reset();
        st(1'b1, 1'b0, 1'b1, 1'b0);
        // page in a protected block runs but hands no word to the array
        page_top = 32'h0001_8000;
        run_page(128);
        repeat (3) @(negedge clk);
        check("words", n_words, 0);
        pulse(1'b0);
        st(1'b1, 1'b0, 1'b1, 1'b0);
        $display("test protection done");
        complete_run();
    end
endmodule
